// [inc/bls_pkg.sv]
// constants and types for the byte load execution block
package bls_pkg;

    // phase lengths in clock ticks
    localparam logic [2:0] BLS_LEN_FETCH  = 3'h4;
    localparam logic [2:0] BLS_LEN_FETCH2 = 3'h4;
    localparam logic [2:0] BLS_LEN_OPER   = 3'h3;
    localparam logic [2:0] BLS_LEN_ADDR   = 3'h5;
    localparam logic [2:0] BLS_LEN_MEMRD  = 3'h3;
    localparam logic [2:0] BLS_LEN_MEMWR  = 3'h3;
    localparam logic [2:0] BLS_LEN_IORD   = 3'h4;

    // whole-instruction budgets in clock ticks
    localparam logic [5:0] BLS_BUD_COPY   = 6'h04;
    localparam logic [5:0] BLS_BUD_TWO    = 6'h07;
    localparam logic [5:0] BLS_BUD_IDX    = 6'h13;
    localparam logic [5:0] BLS_BUD_IO     = 6'h0c;
    localparam logic [5:0] BLS_BUD_PFXNOP = 6'h08;

    // prefix bytes
    localparam logic [7:0] BLS_PFX_FIRST  = 8'hdd;
    localparam logic [7:0] BLS_PFX_SECOND = 8'hfd;
    localparam logic [7:0] BLS_PFX_PORT   = 8'hed;

    // register selector codes
    localparam logic [2:0] BLS_SEL_B      = 3'h0;
    localparam logic [2:0] BLS_SEL_C      = 3'h1;
    localparam logic [2:0] BLS_SEL_H      = 3'h4;
    localparam logic [2:0] BLS_SEL_L      = 3'h5;
    localparam logic [2:0] BLS_SEL_NONE   = 3'h6;
    localparam logic [2:0] BLS_SEL_ACC    = 3'h7;

    // flag register
    localparam int         BLS_NEG_BIT    = 7;
    localparam logic [7:0] BLS_FLAGS_RST  = 8'h00;

    // values after reset
    localparam logic [15:0] BLS_PC_RST    = 16'h0000;
    localparam logic [15:0] BLS_PTR_RST   = 16'h0000;
    localparam logic [7:0]  BLS_REG_RST   = 8'h00;
    localparam logic [7:0]  BLS_DIV_RST   = 8'h00;

    typedef enum logic [2:0] {
        BLS_ST_FETCH  = 3'b000,
        BLS_ST_FETCH2 = 3'b001,
        BLS_ST_OPER   = 3'b010,
        BLS_ST_ADDR   = 3'b011,
        BLS_ST_MEMRD  = 3'b100,
        BLS_ST_MEMWR  = 3'b101,
        BLS_ST_IORD   = 3'b110
    } bls_state_t;

    typedef enum logic [1:0] {
        BLS_PF_NONE   = 2'b00,
        BLS_PF_FIRST  = 2'b01,
        BLS_PF_SECOND = 2'b10,
        BLS_PF_PORT   = 2'b11
    } bls_pfx_t;

    typedef struct packed {
        logic [7:0][7:0] r;
    } bls_rf_t;

    typedef struct packed {
        bls_state_t  st;
        logic [2:0]  tcnt;
        logic [7:0]  div;
        logic [15:0] pc;
        logic [7:0]  ir;
        bls_pfx_t    pfx;
        logic [7:0]  ofs;
        logic [15:0] ea;
        logic [15:0] ix;
        logic [15:0] iy;
        logic [7:0]  flags;
        logic [15:0] mem_addr;
        logic        mem_rd;
        logic        mem_wr;
        logic [7:0]  mem_wdata;
        logic [15:0] io_addr;
        logic        io_rd;
        logic        done;
    } bls_core_t;

endpackage : bls_pkg

// [rtl/bls_addr.sv]
// pointer plus signed offset adder
`timescale 1ns/1ps
module bls_addr
    import bls_pkg::*;
(
    input  wire logic [15:0] base,
    input  wire logic [7:0]  ofs,
    output logic      [15:0] sum
);
    // offset is two's complement, sign extended
    assign sum = base + {{8{ofs[7]}}, ofs};
endmodule : bls_addr

// [rtl/bls_regs.sv]
// byte register file with one write port, one selectable read port and fixed h:l and b:c pair outputs
`timescale 1ns/1ps
module bls_regs
    import bls_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        we,
    input  wire logic [2:0]  waddr,
    input  wire logic [7:0]  wdata,
    input  wire logic [2:0]  raddr,
    output logic      [7:0]  rdata,
    output logic      [15:0] pair_hl,
    output logic      [15:0] pair_bc
);
    bls_rf_t rf_ff;
    bls_rf_t nxt_rf;

    always_comb begin
        nxt_rf = rf_ff;
        for (int i = 0; i < 8; i++) begin
            // code 110 selects nothing
            if (we && waddr == 3'(i) && waddr != BLS_SEL_NONE) begin
                nxt_rf.r[i] = wdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rf_ff <= '{r: {8{BLS_REG_RST}}};
        end else begin
            rf_ff <= nxt_rf;
        end
    end

    assign rdata   = (raddr == BLS_SEL_NONE) ? 8'h00 : rf_ff.r[raddr];
    assign pair_hl = {rf_ff.r[BLS_SEL_H], rf_ff.r[BLS_SEL_L]};
    assign pair_bc = {rf_ff.r[BLS_SEL_B], rf_ff.r[BLS_SEL_C]};
endmodule : bls_regs

// [rtl/bls_core.sv]
// byte load decode and execution core with sign flag
`timescale 1ns/1ps
module bls_core
    import bls_pkg::*;
#(
    parameter logic [7:0] TICK_DIV = 8'h01
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic [7:0]  io_rdata,
    input  wire logic        ptr_load_en,
    input  wire logic        ptr_load_sel,
    input  wire logic [15:0] ptr_load_val,
    output logic      [15:0] mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic      [7:0]  mem_wdata,
    output logic      [15:0] io_addr,
    output logic             io_rd,
    output logic      [7:0]  flags,
    output logic             negative,
    output logic             instr_done
);
    bls_core_t   s_ff;
    bls_core_t   nxt_s;
    logic        tick;
    logic        last;
    logic [2:0]  len;
    logic [7:0]  op;
    logic [7:0]  rd_data;
    logic [15:0] hl;
    logic [15:0] bc;
    logic [15:0] idx_base;
    logic [15:0] idx_sum;
    logic        rf_we;
    logic [2:0]  rf_waddr;
    logic [7:0]  rf_wdata;
    logic        is_store;
    logic        sel_ok_d;
    logic        sel_ok_s;

    bls_regs u_regs (
        .mclk    (mclk),
        .rst     (rst),
        .we      (rf_we),
        .waddr   (rf_waddr),
        .wdata   (rf_wdata),
        .raddr   (op[2:0]),
        .rdata   (rd_data),
        .pair_hl (hl),
        .pair_bc (bc)
    );

    assign idx_base = (s_ff.pfx == BLS_PF_SECOND) ? s_ff.iy : s_ff.ix;

    bls_addr u_addr (
        .base (idx_base),
        .ofs  (s_ff.ofs),
        .sum  (idx_sum)
    );

    assign tick = (s_ff.div == TICK_DIV - 8'h01);

    always_comb begin
        case (s_ff.st)
            BLS_ST_FETCH:  len = BLS_LEN_FETCH;
            BLS_ST_FETCH2: len = BLS_LEN_FETCH2;
            BLS_ST_OPER:   len = BLS_LEN_OPER;
            BLS_ST_ADDR:   len = BLS_LEN_ADDR;
            BLS_ST_MEMRD:  len = BLS_LEN_MEMRD;
            BLS_ST_MEMWR:  len = BLS_LEN_MEMWR;
            BLS_ST_IORD:   len = BLS_LEN_IORD;
            default:       len = BLS_LEN_FETCH;
        endcase
    end

    assign last = tick && (s_ff.tcnt == len - 3'h1);

    // opcode byte arrives on the bus during a fetch phase
    assign op = (s_ff.st == BLS_ST_FETCH || s_ff.st == BLS_ST_FETCH2)
                ? mem_rdata : s_ff.ir;
    assign sel_ok_d = (op[5:3] != BLS_SEL_NONE);
    assign sel_ok_s = (op[2:0] != BLS_SEL_NONE);
    assign is_store = (op[7:3] == 5'b01110);

    always_comb begin
        rf_we    = 1'b0;
        rf_waddr = op[5:3];
        rf_wdata = rd_data;
        if (last) begin
            case (s_ff.st)
                BLS_ST_FETCH: begin
                    // 01 dest source, both real registers
                    rf_we = (op[7:6] == 2'b01) && sel_ok_d && sel_ok_s;
                end
                BLS_ST_OPER: begin
                    rf_we    = (s_ff.pfx == BLS_PF_NONE);
                    rf_wdata = mem_rdata;
                end
                BLS_ST_MEMRD: begin
                    rf_we    = 1'b1;
                    rf_wdata = mem_rdata;
                end
                BLS_ST_IORD: begin
                    rf_we    = 1'b1;
                    rf_wdata = io_rdata;
                end
                default: begin
                    rf_we = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        nxt_s      = s_ff;
        nxt_s.done = 1'b0;
        nxt_s.div  = tick ? 8'h00 : s_ff.div + 8'h01;
        if (tick) begin
            nxt_s.tcnt = last ? 3'h0 : s_ff.tcnt + 3'h1;
        end
        if (ptr_load_en && !ptr_load_sel) begin
            nxt_s.ix = ptr_load_val;
        end
        if (ptr_load_en && ptr_load_sel) begin
            nxt_s.iy = ptr_load_val;
        end
        if (last) begin
            case (s_ff.st)
                BLS_ST_FETCH: begin
                    nxt_s.pc  = s_ff.pc + 16'h0001;
                    nxt_s.ir  = op;
                    nxt_s.pfx = BLS_PF_NONE;
                    nxt_s.ea  = hl;
                    nxt_s.st  = BLS_ST_FETCH;
                    if (op == BLS_PFX_FIRST) begin
                        nxt_s.pfx = BLS_PF_FIRST;
                        nxt_s.st  = BLS_ST_FETCH2;
                    end else if (op == BLS_PFX_SECOND) begin
                        nxt_s.pfx = BLS_PF_SECOND;
                        nxt_s.st  = BLS_ST_FETCH2;
                    end else if (op == BLS_PFX_PORT) begin
                        nxt_s.pfx = BLS_PF_PORT;
                        nxt_s.st  = BLS_ST_FETCH2;
                    end else if (op[7:6] == 2'b00 && op[2:0] == 3'b110
                                 && sel_ok_d) begin
                        nxt_s.st = BLS_ST_OPER;
                    end else if (op[7:6] == 2'b01 && op[2:0] == 3'b110
                                 && sel_ok_d) begin
                        nxt_s.st = BLS_ST_MEMRD;
                    end else if (is_store && sel_ok_s) begin
                        nxt_s.st = BLS_ST_MEMWR;
                    end else begin
                        nxt_s.done = 1'b1;
                    end
                end
                BLS_ST_FETCH2: begin
                    nxt_s.pc = s_ff.pc + 16'h0001;
                    nxt_s.ir = op;
                    nxt_s.st = BLS_ST_FETCH;
                    if (s_ff.pfx == BLS_PF_PORT) begin
                        if (op[7:6] == 2'b01 && op[2:0] == 3'b000
                            && sel_ok_d) begin
                            nxt_s.st = BLS_ST_IORD;
                        end else begin
                            nxt_s.done = 1'b1;
                        end
                    end else if ((op[7:6] == 2'b01 && op[2:0] == 3'b110
                                  && sel_ok_d)
                                 || (is_store && sel_ok_s)) begin
                        nxt_s.st = BLS_ST_OPER;
                    end else begin
                        nxt_s.done = 1'b1;
                    end
                end
                BLS_ST_OPER: begin
                    nxt_s.pc = s_ff.pc + 16'h0001;
                    if (s_ff.pfx == BLS_PF_NONE) begin
                        nxt_s.st   = BLS_ST_FETCH;
                        nxt_s.done = 1'b1;
                    end else begin
                        nxt_s.ofs = mem_rdata;
                        nxt_s.st  = BLS_ST_ADDR;
                    end
                end
                BLS_ST_ADDR: begin
                    nxt_s.ea = idx_sum;
                    nxt_s.st = is_store ? BLS_ST_MEMWR : BLS_ST_MEMRD;
                end
                BLS_ST_IORD: begin
                    nxt_s.flags[BLS_NEG_BIT] = io_rdata[7];
                    nxt_s.st   = BLS_ST_FETCH;
                    nxt_s.done = 1'b1;
                end
                default: begin
                    nxt_s.st   = BLS_ST_FETCH;
                    nxt_s.done = 1'b1;
                end
            endcase
        end
        // bus strobes follow the phase being entered
        nxt_s.mem_rd  = (nxt_s.st == BLS_ST_FETCH)
                        || (nxt_s.st == BLS_ST_FETCH2)
                        || (nxt_s.st == BLS_ST_OPER)
                        || (nxt_s.st == BLS_ST_MEMRD);
        nxt_s.mem_wr  = (nxt_s.st == BLS_ST_MEMWR);
        nxt_s.io_rd   = (nxt_s.st == BLS_ST_IORD);
        nxt_s.io_addr = bc;
        if (nxt_s.st == BLS_ST_MEMRD || nxt_s.st == BLS_ST_MEMWR) begin
            nxt_s.mem_addr = nxt_s.ea;
        end else begin
            nxt_s.mem_addr = nxt_s.pc;
        end
        if (nxt_s.st == BLS_ST_MEMWR && s_ff.st != BLS_ST_MEMWR) begin
            nxt_s.mem_wdata = rd_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_ff <= '{st: BLS_ST_FETCH, tcnt: 3'h0, div: BLS_DIV_RST,
                      pc: BLS_PC_RST, ir: 8'h00, pfx: BLS_PF_NONE,
                      ofs: 8'h00, ea: BLS_PTR_RST, ix: BLS_PTR_RST,
                      iy: BLS_PTR_RST, flags: BLS_FLAGS_RST,
                      mem_addr: BLS_PC_RST, mem_rd: 1'b1, mem_wr: 1'b0,
                      mem_wdata: 8'h00, io_addr: 16'h0000, io_rd: 1'b0,
                      done: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign mem_addr   = s_ff.mem_addr;
    assign mem_rd     = s_ff.mem_rd;
    assign mem_wr     = s_ff.mem_wr;
    assign mem_wdata  = s_ff.mem_wdata;
    assign io_addr    = s_ff.io_addr;
    assign io_rd      = s_ff.io_rd;
    assign flags      = s_ff.flags;
    assign negative   = s_ff.flags[BLS_NEG_BIT];
    assign instr_done = s_ff.done;

    // ticks spent by the instruction that just finished
    logic [5:0] itk_ff;
    logic       copy_op;
    always_ff @(posedge mclk) begin
        if (rst) begin
            itk_ff <= 6'h00;
        end else if (s_ff.done) begin
            itk_ff <= tick ? 6'h01 : 6'h00;
        end else begin
            itk_ff <= itk_ff + (tick ? 6'h01 : 6'h00);
        end
    end
    assign copy_op = s_ff.pfx == BLS_PF_NONE && s_ff.ir[7:6] == 2'b01
                     && s_ff.ir[5:3] != 3'h6 && s_ff.ir[2:0] != 3'h6;

    copy_time_a: assert property (@(posedge mclk) disable iff (rst)
        s_ff.done && copy_op |-> itk_ff == 6'd4)
        else $error("copy not 4 ticks");
    imm_time_a: assert property (@(posedge mclk) disable iff (rst)
        s_ff.done && s_ff.pfx == BLS_PF_NONE && s_ff.ir[7:6] == 2'b00
        && s_ff.ir[2:0] == 3'h6 && s_ff.ir[5:3] != 3'h6
        |-> itk_ff == 6'd7)
        else $error("immediate load not 7 ticks");
    hl_read_a: assert property (@(posedge mclk) disable iff (rst)
        s_ff.done && s_ff.pfx == BLS_PF_NONE && s_ff.ir[7:6] == 2'b01
        && s_ff.ir[2:0] == 3'h6 && s_ff.ir[5:3] != 3'h6
        |-> itk_ff == 6'd7)
        else $error("pointer read not 7 ticks");
    idx_time_a: assert property (@(posedge mclk) disable iff (rst)
        s_ff.done && (s_ff.pfx == BLS_PF_FIRST || s_ff.pfx == BLS_PF_SECOND)
        && $past(s_ff.st == BLS_ST_MEMRD || s_ff.st == BLS_ST_MEMWR)
        |-> itk_ff == 6'd19)
        else $error("indexed access not 19 ticks");
    hl_store_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(mem_wr) && s_ff.pfx == BLS_PF_NONE
        |-> mem_addr == hl ##3 !mem_wr)
        else $error("pointer store address or length wrong");
    idx_addr_a: assert property (@(posedge mclk) disable iff (rst)
        s_ff.st == BLS_ST_ADDR && last
        |=> mem_addr == $past(idx_base + {{8{s_ff.ofs[7]}}, s_ff.ofs}))
        else $error("indexed address wrong");
    neg_flag_a: assert property (@(posedge mclk) disable iff (rst)
        s_ff.st == BLS_ST_IORD && last
        |=> negative == $past(io_rdata[7]))
        else $error("negative flag not from port data");
    flag_hold_a: assert property (@(posedge mclk) disable iff (rst)
        !(s_ff.st == BLS_ST_IORD && last) |=> $stable(flags))
        else $error("flags changed by a load");
    no_sel6_a: assert property (@(posedge mclk) disable iff (rst)
        rf_we |-> rf_waddr != 3'h6)
        else $error("write to selector 110");
endmodule : bls_core

// [sim/bls_mem_model.sv]
// zero-wait memory and port space model for the load core
`timescale 1ns/1ps
module bls_mem_model (
    input  wire logic        mclk,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata,
    input  wire logic [15:0] io_addr,
    input  wire logic        io_rd,
    output logic      [7:0]  io_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] io  [0:255];
    logic [7:0] idle_ff = 8'h5a;

    initial begin
        for (int k = 0; k < 65536; k++) begin
            mem[k] = 8'h00;
        end
        for (int k = 0; k < 256; k++) begin
            io[k] = 8'h00;
        end
    end

    // released bus shows a pattern that moves every cycle
    always_ff @(posedge mclk) begin
        idle_ff <= idle_ff + 8'h3b;
    end

    // byte at mem_addr served while mem_rd is high, idle pattern otherwise
    assign mem_rdata = mem_rd ? mem[mem_addr] : idle_ff;
    assign io_rdata  = io_rd ? io[io_addr[7:0]] : ~idle_ff;

    always_ff @(posedge mclk) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule : bls_mem_model

// [sim/byte_load_execute_and_sign_flag_tb.sv]
// self-checking bench for the byte load core
`timescale 1ns/1ps
module byte_load_execute_and_sign_flag_tb
    import bls_pkg::*;
;
    logic        mclk         = 1'b0;
    logic        rst          = 1'b1;
    logic        ptr_load_en  = 1'b0;
    logic        ptr_load_sel = 1'b0;
    logic [15:0] ptr_load_val = 16'h0000;
    logic [7:0]  mem_rdata;
    logic [7:0]  io_rdata;
    logic [15:0] mem_addr;
    logic        mem_rd;
    logic        mem_wr;
    logic [7:0]  mem_wdata;
    logic [15:0] io_addr;
    logic        io_rd;
    logic [7:0]  flags;
    logic        negative;
    logic        instr_done;
    int          fails        = 0;
    int          comparisons  = 0;

    initial begin
        forever #12.5 mclk = ~mclk;
    end

    bls_core #(.TICK_DIV(8'h01)) uut (
        .mclk         (mclk),
        .rst          (rst),
        .mem_rdata    (mem_rdata),
        .io_rdata     (io_rdata),
        .ptr_load_en  (ptr_load_en),
        .ptr_load_sel (ptr_load_sel),
        .ptr_load_val (ptr_load_val),
        .mem_addr     (mem_addr),
        .mem_rd       (mem_rd),
        .mem_wr       (mem_wr),
        .mem_wdata    (mem_wdata),
        .io_addr      (io_addr),
        .io_rd        (io_rd),
        .flags        (flags),
        .negative     (negative),
        .instr_done   (instr_done)
    );

    bls_mem_model mem_i (
        .mclk      (mclk),
        .mem_addr  (mem_addr),
        .mem_rd    (mem_rd),
        .mem_wr    (mem_wr),
        .mem_wdata (mem_wdata),
        .mem_rdata (mem_rdata),
        .io_addr   (io_addr),
        .io_rd     (io_rd),
        .io_rdata  (io_rdata)
    );

    task automatic final_report;
        if (fails == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // waits for one completion pulse, returns cycles taken
    task automatic wait_done(input bit load_ptrs, output int cnt);
        cnt = 0;
        do begin
            if (load_ptrs) begin
                ptr_load_en  <= (cnt < 2);
                ptr_load_sel <= cnt[0];
                ptr_load_val <= cnt[0] ? 16'h2000 : 16'h1234;
            end
            @(posedge mclk);
            cnt++;
        end while (instr_done !== 1'b1 && cnt < 40);
        if (instr_done !== 1'b1) begin
            fails++;
            final_report();
        end
    endtask : wait_done

    // reset, load program at 0000, check each instruction's length after the first
    task automatic run(input logic [7:0] p[$], input int b[$]);
        int cnt;
        rst <= 1'b1;
        for (int k = 0; k < 32; k++) begin
            mem_i.mem[k] = 8'h00;
        end
        foreach (p[i]) begin
            mem_i.mem[i] = p[i];
        end
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        wait_done(1'b0, cnt);
        foreach (b[i]) begin
            wait_done(i == 0, cnt);
            chk("ticks", 16'(b[i]), 16'(cnt));
        end
        repeat (4) @(posedge mclk);
    endtask : run

    // immediates into h, l, b; copy b to c; store c through h:l
    task automatic t_imm_copy_store;
        run('{8'h00, 8'h26, 8'h40, 8'h2e, 8'h10, 8'h06, 8'h80,
              8'h48, 8'h71}, '{7, 7, 7, 4, 7});
        chk("store via pair", 16'h0080, {8'h00, mem_i.mem[16'h4010]});
        chk("flags after copy", 16'h0000, {8'h00, flags});
        chk("negative after load", 16'h0000, {15'h0, negative});
    endtask : t_imm_copy_store

    // read through h:l into e, store e elsewhere, then two no-ops
    task automatic t_pair_read;
        mem_i.mem[16'h5020] = 8'hc3;
        run('{8'h00, 8'h26, 8'h50, 8'h2e, 8'h20, 8'h5e, 8'h2e, 8'h21,
              8'h73, 8'h76, 8'h36}, '{7, 7, 7, 7, 7, 4, 4});
        chk("read via pair", 16'h00c3, {8'h00, mem_i.mem[16'h5021]});
        chk("flags after read", 16'h0000, {8'h00, flags});
    endtask : t_pair_read

    // indexed reads and stores, offsets -2, +5, -1 and +127
    task automatic t_indexed;
        mem_i.mem[16'h1232] = 8'ha5;
        mem_i.mem[16'h1fff] = 8'h3c;
        run('{8'h00, BLS_PFX_FIRST, 8'h56, 8'hfe,
              BLS_PFX_SECOND, 8'h72, 8'h05,
              BLS_PFX_SECOND, 8'h5e, 8'hff,
              BLS_PFX_FIRST, 8'h73, 8'h7f}, '{19, 19, 19, 19});
        chk("second ptr store", 16'h00a5, {8'h00, mem_i.mem[16'h2005]});
        chk("first ptr store", 16'h003c, {8'h00, mem_i.mem[16'h12b3]});
        chk("ofs read", 16'h003c, {8'h00, mem_i.mem[16'h12b3]});
        chk("flags indexed", 16'h0000, {8'h00, flags});
    endtask : t_indexed

    // port read of a negative byte, then a copy that keeps the flag
    task automatic t_port_negative;
        mem_i.io[8'h10] = 8'h80;
        run('{8'h00, 8'h06, 8'h00, 8'h0e, 8'h10, BLS_PFX_PORT, 8'h78,
              8'h26, 8'h60, 8'h2e, 8'h00, 8'h47, 8'h70},
            '{7, 7, 12, 7, 7, 4, 7});
        chk("acc stored", 16'h0080, {8'h00, mem_i.mem[16'h6000]});
        chk("flags negative", 16'h0080, {8'h00, flags});
        chk("negative set", 16'h0001, {15'h0, negative});
        chk("sign bit", 16'h0001, {15'h0, flags[BLS_NEG_BIT]});
    endtask : t_port_negative

    // port read of +127 into c clears the flag
    task automatic t_port_positive;
        mem_i.io[8'h11] = 8'h7f;
        run('{8'h00, 8'h0e, 8'h11, BLS_PFX_PORT, 8'h48, 8'h26, 8'h60,
              8'h2e, 8'h01, 8'h71}, '{7, 12, 7, 7, 7});
        chk("port data stored", 16'h007f, {8'h00, mem_i.mem[16'h6001]});
        chk("flags positive", 16'h0000, {8'h00, flags});
        chk("negative clear", 16'h0000, {15'h0, negative});
        chk("port address", 16'h007f, io_addr);
    endtask : t_port_positive

    initial begin
        t_imm_copy_store();
        t_pair_read();
        t_indexed();
        t_port_negative();
        t_port_positive();
        final_report();
    end
endmodule : byte_load_execute_and_sign_flag_tb
